// File: inc/lpm_pkg.sv
// Package with types and constants of the low-power mode controller.
package lpm_pkg;

  // Mode selection written by software before the wait instruction.
  localparam logic [1:0] LPM_SEL_SLEEP   = 2'h0;
  localparam logic [1:0] LPM_SEL_ALLSTOP = 2'h1;
  localparam logic [1:0] LPM_SEL_STANDBY = 2'h2;
  localparam logic [1:0] LPM_SEL_RESET   = 2'h0;

  // Wake countdown reload; the wake sequence waits this value plus one cycles between clock release and interrupt delivery.
  localparam logic [3:0] LPM_RELEASE_CYCLES = 4'h2;

  // Controller states.
  typedef enum logic [2:0] {
    LPM_RUN     = 3'b000,
    LPM_SLEEP   = 3'b001,
    LPM_ALLSTOP = 3'b010,
    LPM_STANDBY = 3'b011,
    LPM_WAKE    = 3'b100
  } lpm_state_type;

  // Own-setting run requests of units that may keep running.
  typedef struct packed {
    logic main_osc;
    logic sub_osc;
    logic fast_internal_osc;
    logic slow_internal_osc;
    logic wdog_osc;
    logic main_synth;
    logic special_purpose_synth;
    logic usb;
    logic eight_bit_timer;
    logic output_disable_unit;
    logic peripherals;
  } lpm_req_type;

  // Clock enables for every gated unit.
  typedef struct packed {
    logic main_osc;
    logic sub_osc;
    logic fast_internal_osc;
    logic slow_internal_osc;
    logic wdog_osc;
    logic main_synth;
    logic special_purpose_synth;
    logic core;
    logic main_ram;
    logic standby_ram;
    logic flash;
    logic usb;
    logic watchdog_counter;
    logic eight_bit_timer;
    logic output_disable_unit;
    logic peripherals;
    logic io_ports;
    logic por;
  } lpm_gate_type;

endpackage

// File: rtl/lpm_sync.sv
// Two-flop synchroniser for a bus of asynchronous levels.
`timescale 1ns/10ps
module lpm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  // State: the first stage feeds only the second stage.
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } lpm_sync_state_type;

  lpm_sync_state_type r;
  lpm_sync_state_type next_r;

  // Shift one stage per clock.
  always_comb begin
    next_r    = r;
    next_r.s1 = d_i;
    next_r.s2 = r.s1;
  end

  // Registers clear to zero under reset.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q_o = r.s2;

endmodule

// File: rtl/lpm_ctrl.sv
// Low-power mode controller: sleep, all-module clock stop and software standby.
//
// Overview of operation
// - Sleep entered only after mode register write then wait instruction.
// - Interrupt or reset ends any low-power mode; core resumes by servicing interrupt.
// - Core halted in sleep with register contents kept.
// - Main and standby RAM accessible in sleep; flash keeps running.
// - Flash runs in sleep, halted with contents kept in the deeper modes.
// - Watchdog counter halted in all three modes regardless of its setting.
// - In sleep other units and oscillators follow own settings; I/O ports run.
// - All-module clock stop selected by register then entered by wait instruction.
// - USB stopped, RAMs halted with contents in clock stop and standby.
// - Eight-bit timers follow own settings in clock stop; other peripherals halt.
// - Output-disable unit may keep operating in all-module clock stop.
// - I/O pins hold last state in clock stop and standby.
// - Software standby entered by register setting then wait instruction.
// - Standby stops fast internal oscillator, main and special-purpose synths.
// - Standby stops slow internal oscillator; main and sub oscillators follow settings.
// - Watchdog oscillator may run in all modes for watchdog, clock, detector.
// - Standby halts eight-bit timers and output-disable unit with contents kept.
// - Power-on reset circuit always operates in every mode.
// - Halted units keep register values and suspend all activity.
// - Possibly-operating units follow their own control settings.
// - Output-disable interrupt does not wake clock stop; flag kept, raised after wake.
`timescale 1ns/10ps
module lpm_ctrl #(
  parameter int IRQ_WIDTH = 8
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire logic                 mode_write_i,
  input  wire logic [1:0]           mode_sel_i,
  input  wire logic                 wait_exec_i,
  input  wire logic [IRQ_WIDTH-1:0] irq_i,
  input  wire logic                 odu_irq_i,
  input  wire logic                 odu_irq_en_i,
  input  wire logic                 odu_flag_clear_i,
  input  wire lpm_pkg::lpm_req_type req_i,
  output lpm_pkg::lpm_gate_type     gate_o,
  output logic                      core_halt_o,
  output logic                      port_hold_o,
  output logic [IRQ_WIDTH-1:0]      irq_deliver_o,
  output logic                      odu_irq_o,
  output logic                      odu_flag_o,
  output lpm_pkg::lpm_state_type    mode_o
);

  // All state of the controller.
  typedef struct packed {
    lpm_pkg::lpm_state_type state;
    logic [1:0]             mode_sel;
    logic                   armed;
    logic [IRQ_WIDTH-1:0]   irq_hold;
    logic [IRQ_WIDTH-1:0]   irq_deliver;
    logic                   odu_flag;
    logic                   odu_irq;
    logic [3:0]             release_cnt;
    lpm_pkg::lpm_gate_type  gate;
    logic                   core_halt;
    logic                   port_hold;
  } lpm_ctrl_state_type;

  lpm_ctrl_state_type r;
  lpm_ctrl_state_type next_r;

  logic [IRQ_WIDTH:0]   sync_q;
  logic [IRQ_WIDTH-1:0] irq_sync;
  logic                 odu_sync;
  logic                 any_irq;

  // Interrupt pins arrive from other logic domains, so they are synchronised first.
  lpm_sync #(
    .WIDTH (IRQ_WIDTH + 1)
  ) u_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .d_i     ({odu_irq_i, irq_i}),
    .q_o     (sync_q)
  );

  // The top bit carries the output-disable source, the rest the wake sources.
  assign odu_sync = sync_q[IRQ_WIDTH];
  assign irq_sync = sync_q[IRQ_WIDTH-1:0];
  assign any_irq  = |irq_sync;

  // Gate pattern for a given state; a halted unit simply loses its clock
  // so that its registers keep their values.
  function automatic lpm_pkg::lpm_gate_type gate_for(
    input lpm_pkg::lpm_state_type st,
    input lpm_pkg::lpm_req_type   rq
  );
    lpm_pkg::lpm_gate_type g;
    g                       = '0;
    g.por                   = 1'b1;
    g.wdog_osc              = rq.wdog_osc;
    g.main_osc              = rq.main_osc;
    g.sub_osc               = rq.sub_osc;
    case (st)
      lpm_pkg::LPM_SLEEP: begin
        g.core                  = 1'b0;
        g.main_ram              = 1'b1;
        g.standby_ram           = 1'b1;
        g.flash                 = 1'b1;
        g.watchdog_counter      = 1'b0;
        g.fast_internal_osc     = rq.fast_internal_osc;
        g.slow_internal_osc     = rq.slow_internal_osc;
        g.main_synth            = rq.main_synth;
        g.special_purpose_synth = rq.special_purpose_synth;
        g.usb                   = rq.usb;
        g.eight_bit_timer       = rq.eight_bit_timer;
        g.output_disable_unit   = rq.output_disable_unit;
        g.peripherals           = rq.peripherals;
        g.io_ports              = 1'b1;
      end
      lpm_pkg::LPM_ALLSTOP: begin
        g.fast_internal_osc     = rq.fast_internal_osc;
        g.slow_internal_osc     = rq.slow_internal_osc;
        g.main_synth            = rq.main_synth;
        g.special_purpose_synth = rq.special_purpose_synth;
        g.eight_bit_timer       = rq.eight_bit_timer;
        g.output_disable_unit   = rq.output_disable_unit;
        // The rest, apart from POR and the main, sub and watchdog oscillators, loses its clock, so its registers keep their last values.
        g.core                  = 1'b0;
        g.main_ram              = 1'b0;
        g.standby_ram           = 1'b0;
        g.flash                 = 1'b0;
        g.usb                   = 1'b0;
        g.watchdog_counter      = 1'b0;
        g.peripherals           = 1'b0;
        // Pins stay frozen through port_hold_o while the port logic is gated.
        g.io_ports              = 1'b0;
      end
      lpm_pkg::LPM_STANDBY: begin
        // Fast and slow internal oscillators and both synths are forced off.
        g.fast_internal_osc     = 1'b0;
        g.slow_internal_osc     = 1'b0;
        g.main_synth            = 1'b0;
        g.special_purpose_synth = 1'b0;
        g.eight_bit_timer       = 1'b0;
        g.output_disable_unit   = 1'b0;
        // The rest is halted as in clock stop; only the power-on reset circuit,
        // the watchdog oscillator and the main and sub oscillators may still run.
        g.core                  = 1'b0;
        g.main_ram              = 1'b0;
        g.standby_ram           = 1'b0;
        g.flash                 = 1'b0;
        g.usb                   = 1'b0;
        g.watchdog_counter      = 1'b0;
        g.peripherals           = 1'b0;
        g.io_ports              = 1'b0;
      end
      default: begin
        // Running: everything clocked, units with own enables follow them.
        g.fast_internal_osc     = rq.fast_internal_osc;
        g.slow_internal_osc     = rq.slow_internal_osc;
        g.main_synth            = rq.main_synth;
        g.special_purpose_synth = rq.special_purpose_synth;
        g.core                  = 1'b1;
        g.main_ram              = 1'b1;
        g.standby_ram           = 1'b1;
        g.flash                 = 1'b1;
        g.usb                   = rq.usb;
        g.watchdog_counter      = 1'b1;
        g.eight_bit_timer       = rq.eight_bit_timer;
        g.output_disable_unit   = rq.output_disable_unit;
        g.peripherals           = rq.peripherals;
        g.io_ports              = 1'b1;
      end
    endcase
    return g;
  endfunction

  // Next-state logic.
  always_comb begin
    next_r             = r;
    next_r.irq_deliver = '0;

    // A write records the selected mode and arms entry; the wait alone does nothing.
    if (mode_write_i) begin
      next_r.mode_sel = mode_sel_i;
      next_r.armed    = 1'b1;
    end

    // Output-disable source flag: set wins over a simultaneous clear.
    if (odu_flag_clear_i) begin
      next_r.odu_flag = 1'b0;
    end
    if (odu_sync && odu_irq_en_i) begin
      next_r.odu_flag = 1'b1;
    end

    case (r.state)
      lpm_pkg::LPM_RUN: begin
        next_r.irq_hold = '0;
        if (wait_exec_i && r.armed) begin
          // The entry consumes the old arm; a write in this same cycle arms the next one.
          next_r.armed = mode_write_i;
          case (r.mode_sel)
            lpm_pkg::LPM_SEL_ALLSTOP: next_r.state = lpm_pkg::LPM_ALLSTOP;
            lpm_pkg::LPM_SEL_STANDBY: next_r.state = lpm_pkg::LPM_STANDBY;
            default:                  next_r.state = lpm_pkg::LPM_SLEEP;
          endcase
        end
      end
      lpm_pkg::LPM_SLEEP, lpm_pkg::LPM_ALLSTOP, lpm_pkg::LPM_STANDBY: begin
        // Only ordinary sources wake; the output-disable source merely pends.
        if (any_irq) begin
          next_r.irq_hold    = irq_sync;
          next_r.release_cnt = lpm_pkg::LPM_RELEASE_CYCLES;
          next_r.state       = lpm_pkg::LPM_WAKE;
        end
      end
      lpm_pkg::LPM_WAKE: begin
        // Clocks already run again here; hand over the interrupt afterwards.
        if (r.release_cnt == 4'h0) begin
          next_r.irq_deliver = r.irq_hold;
          next_r.state       = lpm_pkg::LPM_RUN;
        end else begin
          next_r.release_cnt = r.release_cnt - 4'h1;
        end
      end
      default: begin
        next_r.state = lpm_pkg::LPM_RUN;
      end
    endcase

    // The pending output-disable interrupt is raised only while running.
    next_r.odu_irq = next_r.odu_flag && (next_r.state == lpm_pkg::LPM_RUN);

    // Enables change only on a clock edge, so each unit sees whole cycles.
    next_r.gate      = gate_for(next_r.state == lpm_pkg::LPM_WAKE ? lpm_pkg::LPM_RUN
                                                               : next_r.state, req_i);
    next_r.core_halt = (next_r.state != lpm_pkg::LPM_RUN);
    next_r.port_hold = (next_r.state == lpm_pkg::LPM_ALLSTOP) ||
                       (next_r.state == lpm_pkg::LPM_STANDBY);
  end

  // State register; reset returns to running with core, RAM, flash, watchdog counter, I/O port and POR clocks enabled, all others off.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r                          <= '0;
      r.state                    <= lpm_pkg::LPM_RUN;
      r.mode_sel                 <= lpm_pkg::LPM_SEL_RESET;
      r.gate.core                <= 1'b1;
      r.gate.main_ram            <= 1'b1;
      r.gate.standby_ram         <= 1'b1;
      r.gate.flash               <= 1'b1;
      r.gate.watchdog_counter    <= 1'b1;
      r.gate.io_ports            <= 1'b1;
      r.gate.por                 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign gate_o        = r.gate;
  assign core_halt_o   = r.core_halt;
  assign port_hold_o   = r.port_hold;
  assign irq_deliver_o = r.irq_deliver;
  assign odu_irq_o     = r.odu_irq;
  assign odu_flag_o    = r.odu_flag;
  assign mode_o        = r.state;

endmodule

// File: testbench/lpm_ctrl_monitor.sv
// Port checker of the low-power mode controller, bound to its top module.
`timescale 1ns/10ps
module lpm_ctrl_monitor #(
  parameter int IRQ_WIDTH = 8
) (
  input wire logic                   clock_i,
  input wire logic                   rst_i,
  input wire logic                   mode_write_i,
  input wire logic [1:0]             mode_sel_i,
  input wire logic                   wait_exec_i,
  input wire logic [IRQ_WIDTH-1:0]   irq_i,
  input wire lpm_pkg::lpm_req_type   req_i,
  input wire lpm_pkg::lpm_gate_type  gate_o,
  input wire logic                   core_halt_o,
  input wire logic                   port_hold_o,
  input wire logic [IRQ_WIDTH-1:0]   irq_deliver_o,
  input wire lpm_pkg::lpm_state_type mode_o
);
  logic       armed;
  logic [1:0] sel_q;
  logic       run, alls, sby, deep;

  // Short mode decodes keep the properties readable.
  assign run  = mode_o == lpm_pkg::LPM_RUN;
  assign alls = mode_o == lpm_pkg::LPM_ALLSTOP;
  assign sby  = mode_o == lpm_pkg::LPM_STANDBY;
  assign deep = alls | sby;

  // A write arms one entry and a wait taken in run consumes it.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      armed <= 1'b0;
      sel_q <= lpm_pkg::LPM_SEL_RESET;
    end else begin
      armed <= mode_write_i | (armed & ~(wait_exec_i & run));
      if (mode_write_i) begin
        sel_q <= mode_sel_i;
      end
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_wait_unarmed: assert property (run && wait_exec_i && !armed |=> run)
    else $error("wait without write left run");
  a_wait_entry: assert property (run && wait_exec_i && armed |=>
    mode_o == (sel_q == 2'h1 ? lpm_pkg::LPM_ALLSTOP :
               sel_q == 2'h2 ? lpm_pkg::LPM_STANDBY : lpm_pkg::LPM_SLEEP))
    else $error("wrong mode entered");
  a_core_halted: assert property (!run && mode_o != lpm_pkg::LPM_WAKE |->
    core_halt_o && !gate_o.core && !gate_o.watchdog_counter) else $error("core not halted");
  a_deep_halt: assert property (deep |-> port_hold_o && !gate_o.flash &&
    !gate_o.main_ram && !gate_o.standby_ram && !gate_o.usb) else $error("deep mode unit on");
  a_allstop_own: assert property (alls && $stable(req_i) |->
    gate_o.eight_bit_timer == req_i.eight_bit_timer && !gate_o.peripherals &&
    gate_o.output_disable_unit == req_i.output_disable_unit) else $error("clock stop gates");
  a_standby_off: assert property (sby |-> !gate_o.fast_internal_osc &&
    !gate_o.slow_internal_osc && !gate_o.main_synth && !gate_o.special_purpose_synth &&
    !gate_o.eight_bit_timer && !gate_o.output_disable_unit) else $error("standby unit on");
  a_por_wdog: assert property ($stable(req_i) && !$past(rst_i) |-> gate_o.por &&
    gate_o.wdog_osc == req_i.wdog_osc) else $error("por or watchdog oscillator gate");
  a_quiet_hold: assert property ((alls && irq_i == '0) [*3] |=> alls)
    else $error("clock stop left without interrupt");
  a_deliver_run: assert property (irq_deliver_o != '0 |-> run && !core_halt_o &&
    gate_o.core && gate_o.flash) else $error("interrupt before clocks released");
  a_wake_bound: assert property ($rose(mode_o == lpm_pkg::LPM_WAKE) |->
    ##[1:8] irq_deliver_o != '0) else $error("wake without delivery");
endmodule

bind lpm_ctrl lpm_ctrl_monitor #(.IRQ_WIDTH(IRQ_WIDTH)) i_mon (.clock_i, .rst_i, .mode_write_i,
  .mode_sel_i, .wait_exec_i, .irq_i, .req_i, .gate_o, .core_halt_o, .port_hold_o,
  .irq_deliver_o, .mode_o);

// File: testbench/lpm_core_model.sv
// Core model that issues the mode write and the wait instruction on command.
`timescale 1ns/10ps
module lpm_core_model (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       skip_write_i,
  input  wire logic [1:0] sel_i,
  output logic            mode_write_o,
  output logic [1:0]      mode_sel_o,
  output logic            wait_exec_o
);
  logic go_q;

  // Write first, wait one cycle later; the select toggles whenever go_i is low, as outside a write it means nothing.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      go_q <= 1'b0;
      mode_write_o <= 1'b0;
      mode_sel_o <= 2'h0;
      wait_exec_o <= 1'b0;
    end else begin
      go_q <= go_i;
      mode_write_o <= go_i & ~skip_write_i;
      mode_sel_o <= go_i ? sel_i : ~mode_sel_o;
      wait_exec_o <= go_q;
    end
  end
endmodule

// File: testbench/tb_lpm_ctrl.sv
// Self-checking bench of the low-power mode controller.
`timescale 1ns/10ps
module tb_lpm_ctrl;
  logic clock_i, rst_i, go, skip, mode_write_i, wait_exec_i;
  logic odu_irq_i, odu_irq_en_i, odu_flag_clear_i, core_halt_o, port_hold_o, odu_irq_o;
  logic odu_flag_o;
  logic [1:0] sel, mode_sel_i;
  logic [7:0] irq_i, irq_deliver_o;
  lpm_pkg::lpm_req_type req_i;
  lpm_pkg::lpm_gate_type gate_o;
  lpm_pkg::lpm_state_type mode_o;
  logic [31:0] seed;
  int fail_count, checks;

  lpm_core_model i_core (.clock_i, .rst_i, .go_i(go), .skip_write_i(skip), .sel_i(sel),
    .mode_write_o(mode_write_i), .mode_sel_o(mode_sel_i), .wait_exec_o(wait_exec_i));
  lpm_ctrl i_dut (.clock_i, .rst_i, .mode_write_i, .mode_sel_i, .wait_exec_i, .irq_i,
    .odu_irq_i, .odu_irq_en_i, .odu_flag_clear_i, .req_i, .gate_o, .core_halt_o,
    .port_hold_o, .irq_deliver_o, .odu_irq_o, .odu_flag_o, .mode_o);

  // A 100 ns clock.
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic lpm_pkg::lpm_state_type exp_mode(logic [1:0] s, logic k);
    if (k) return lpm_pkg::LPM_RUN;
    if (s == 2'h1) return lpm_pkg::LPM_ALLSTOP;
    if (s == 2'h2) return lpm_pkg::LPM_STANDBY;
    return lpm_pkg::LPM_SLEEP;
  endfunction

  // Own-setting units follow the request; the mode decides the rest.
  function automatic lpm_pkg::lpm_gate_type exp_gate(lpm_pkg::lpm_state_type m,
                                                     lpm_pkg::lpm_req_type r);
    logic sb, dp, rn;
    sb = m == lpm_pkg::LPM_STANDBY;
    dp = sb || m == lpm_pkg::LPM_ALLSTOP;
    rn = m == lpm_pkg::LPM_RUN || m == lpm_pkg::LPM_WAKE;
    return '{r.main_osc, r.sub_osc, r.fast_internal_osc & !sb, r.slow_internal_osc & !sb,
      r.wdog_osc, r.main_synth & !sb, r.special_purpose_synth & !sb, rn, !dp, !dp, !dp,
      r.usb & !dp, rn, r.eight_bit_timer & !sb, r.output_disable_unit & !sb,
      r.peripherals & !dp, !dp, 1'b1};
  endfunction

  task automatic chk(string name, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic enter(logic [1:0] s, logic k);
    lpm_pkg::lpm_state_type m;
    m = exp_mode(s, k);
    @(posedge clock_i);
    go <= 1'b1;
    sel <= s;
    skip <= k;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    chk("mode", 32'(m), 32'(mode_o));
    chk("gates", 32'(exp_gate(m, req_i)), 32'(gate_o));
    chk("hold", 32'(s inside {2'h1, 2'h2} && !k), 32'(port_hold_o));
    chk("halt", 32'(!k), 32'(core_halt_o));
  endtask

  // The interrupt stays up until the core has been handed it.
  task automatic wake(logic [2:0] b);
    int n;
    @(posedge clock_i);
    irq_i <= 8'h01 << b;
    for (n = 0; n < 20 && irq_deliver_o === 8'h00; n++) begin
      @(negedge clock_i);
    end
    chk("deliver", 32'(8'h01 << b), 32'(irq_deliver_o));
    chk("wake mode", 32'(lpm_pkg::LPM_RUN), 32'(mode_o));
    chk("wake gates", 32'(exp_gate(lpm_pkg::LPM_RUN, req_i)), 32'(gate_o));
    if (n == 20) begin
      fail_count++;
      give_verdict();
    end
    @(posedge clock_i);
    irq_i <= 8'h00;
  endtask

  // Reset, a refused wait, then every mode select twice with random unit settings.
  initial begin
    rst_i = 1'b1;
    {go, skip, sel, irq_i, odu_irq_i, odu_irq_en_i, odu_flag_clear_i} = '0;
    seed = 32'hCFA9;
    req_i = lpm_pkg::lpm_req_type'(seed[10:0]);
    fail_count = 0;
    checks = 0;
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    chk("reset gates", 32'h000007A3, 32'(gate_o));
    @(posedge clock_i);
    rst_i <= 1'b0;
    enter(2'h2, 1'b1);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      @(posedge clock_i);
      req_i <= lpm_pkg::lpm_req_type'(seed[10:0]);
      enter(i[1:0], 1'b0);
      if (i[1:0] == 2'h1) begin
        @(posedge clock_i);
        odu_irq_en_i <= 1'b1;
        odu_irq_i <= 1'b1;
        repeat (6) @(negedge clock_i);
        chk("odu stays", 32'(lpm_pkg::LPM_ALLSTOP), 32'(mode_o));
        chk("odu flag", 32'h1, 32'(odu_flag_o));
        chk("odu early", 32'h0, 32'(odu_irq_o));
        @(posedge clock_i);
        odu_irq_i <= 1'b0;
      end
      wake(seed[14:12]);
      if (i[1:0] == 2'h1) begin
        @(negedge clock_i);
        chk("odu late", 32'h1, 32'(odu_irq_o));
        @(posedge clock_i);
        odu_flag_clear_i <= 1'b1;
        @(posedge clock_i);
        odu_flag_clear_i <= 1'b0;
        @(negedge clock_i);
        chk("odu clear", 32'h0, 32'(odu_flag_o));
        chk("odu irq off", 32'h0, 32'(odu_irq_o));
        // A fresh source reaches the flag in the very cycle of a clear and must win.
        @(posedge clock_i);
        odu_irq_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        odu_flag_clear_i <= 1'b1;
        @(posedge clock_i);
        odu_irq_i <= 1'b0;
        @(negedge clock_i);
        chk("odu set wins", 32'h1, 32'(odu_flag_o));
        repeat (3) @(posedge clock_i);
        odu_flag_clear_i <= 1'b0;
        @(negedge clock_i);
        chk("odu cleared", 32'h0, 32'(odu_flag_o));
      end
    end
    // A reset in the middle of standby ends it and restores the reset gate pattern.
    enter(lpm_pkg::LPM_SEL_STANDBY, 1'b0);
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    chk("mid reset mode", 32'(lpm_pkg::LPM_RUN), 32'(mode_o));
    chk("mid reset halt", 32'h0, 32'(core_halt_o));
    chk("mid reset gates", 32'h000007A3, 32'(gate_o));
    give_verdict();
  end
endmodule
